/* rtl/cdr_regs.sv */
// Control and status register bank of the clock and data recovery receiver.
// Assumes a serial-port slave clocked by ref_clk presents single-cycle register reads and
// writes; status from the recovery core is asynchronous and is synchronised here.
//
// How it works
// - Phase code saturates to minus thirty..thirty
// - Each phase step is one sixtieth UI
// - Byte select picks one of five bytes
// - Signal-loss status bit is one when lost
// - Sticky lock-loss set until software clears
// - Lock one when acquiring, rate one complete
// - Lock source: zero data, one reference
// - Lock-loss pin normal or follows sticky flag
// - Write one then zero clears sticky flag
// - Write one then zero clears rate flag
// - Write one then zero starts acquisition
// - Squelch mode: both outputs or one
`include "cdr_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module cdr_regs
  import cdr_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        reg_wr_en,
  input  wire logic [7:0]  reg_wr_addr,
  input  wire logic [7:0]  reg_wr_data,
  input  wire logic        reg_rd_en,
  input  wire logic [7:0]  reg_rd_addr,
  output logic      [7:0]  reg_rd_data,
  input  wire logic        core_signal_loss,
  input  wire logic        core_lock_loss,
  input  wire logic        core_rate_done,
  input  wire logic        core_coarse_lsb,
  input  wire logic        core_ber_done,
  input  wire logic [39:0] core_error_count,
  input  wire logic [5:0]  core_ber_converter_input,
  output logic             lock_to_reference,
  output logic             measure_start,
  output logic      [1:0]  ref_range,
  output logic      [3:0]  div_ratio_exp,
  output logic             start_acquisition,
  output logic             lock_loss_pin,
  output logic             signal_loss_pin,
  output logic             squelch_clk,
  output logic             squelch_data,
  output logic      [8:0]  upper_rate_bound,
  output logic      [8:0]  lower_rate_bound,
  output logic      [5:0]  phase_code,
  output logic      [2:0]  bit_window_sel,
  output logic             ber_start
);

  // ========================================================================
  // Decoding helpers
  function automatic logic [5:0] clamp_phase(input logic [5:0] raw);
    logic signed [5:0] v;
    v = $signed(raw);
    if (v > `CDR_PHASE_MAX) begin
      clamp_phase = `CDR_PHASE_MAX;
    end else if (v < `CDR_PHASE_MIN) begin
      clamp_phase = `CDR_PHASE_MIN;
    end else begin
      clamp_phase = raw;
    end
  endfunction : clamp_phase

  function automatic logic [3:0] clamp_div(input logic [3:0] raw);
    if (raw > `CDR_DIV_MAX) begin
      clamp_div = `CDR_DIV_MAX;
    end else begin
      clamp_div = raw;
    end
  endfunction : clamp_div

  function automatic logic [7:0] pick_byte(input logic [39:0] cnt, input logic [2:0] sel);
    logic [7:0] b;
    b = `CDR_RST_BYTE;
    if (sel < `CDR_ERR_BYTES) begin
      b = cnt[{sel, 3'h0} +: 8];
    end
    pick_byte = b;
  endfunction : pick_byte

  // ========================================================================
  // Synchronisers for core status
  logic [`CDR_NUM_ASYNC-1:0] async_bus;
  logic [`CDR_NUM_ASYNC-1:0] sync_bus;

  assign async_bus = {core_ber_converter_input, core_error_count, core_ber_done,
                      core_coarse_lsb, core_rate_done, core_lock_loss, core_signal_loss};

  genvar gi;
  generate
    for (gi = 0; gi < `CDR_NUM_ASYNC; gi++) begin : g_sync
      cdr_sync u_sync (
        .ref_clk  (ref_clk),
        .sys_rst  (sys_rst),
        .async_in (async_bus[gi]),
        .sync_out (sync_bus[gi])
      );
    end
  endgenerate

  logic        loss_s;
  logic        lock_s;
  logic        rate_s;
  logic        coarse_s;
  logic        ber_done_s;
  logic [39:0] err_s;
  logic [5:0]  dac_s;

  assign loss_s     = sync_bus[0];
  assign lock_s     = sync_bus[1];
  assign rate_s     = sync_bus[2];
  assign coarse_s   = sync_bus[3];
  assign ber_done_s = sync_bus[4];
  assign err_s      = sync_bus[44:5];
  assign dac_s      = sync_bus[50:45];

  // ========================================================================
  // Write-1-then-0 sequence detectors
  logic [`CDR_NUM_SEQ-1:0] seq_wr;
  logic [`CDR_NUM_SEQ-1:0] seq_bit;
  logic [`CDR_NUM_SEQ-1:0] seq_fire;

  logic wr_ctrl_b;
  logic wr_ber_ctl;

  assign wr_ctrl_b  = reg_wr_en && (reg_wr_addr == `CDR_ADDR_CTL_B);
  assign wr_ber_ctl = reg_wr_en && (reg_wr_addr == `CDR_ADDR_BER_CTL_A);

  assign seq_wr[`CDR_SEQ_CLR_STICKY]  = wr_ctrl_b;
  assign seq_bit[`CDR_SEQ_CLR_STICKY] = reg_wr_data[`CDR_CB_CLR_STICKY];
  assign seq_wr[`CDR_SEQ_CLR_RATE]    = wr_ctrl_b;
  assign seq_bit[`CDR_SEQ_CLR_RATE]   = reg_wr_data[`CDR_CB_CLR_RATE];
  assign seq_wr[`CDR_SEQ_ACQUIRE]     = wr_ctrl_b;
  assign seq_bit[`CDR_SEQ_ACQUIRE]    = reg_wr_data[`CDR_CB_ACQUIRE];
  assign seq_wr[`CDR_SEQ_BER_START]   = wr_ber_ctl;
  assign seq_bit[`CDR_SEQ_BER_START]  = reg_wr_data[`CDR_BA_START];

  generate
    for (gi = 0; gi < `CDR_NUM_SEQ; gi++) begin : g_seq
      cdr_seq u_seq (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .wr_en   (seq_wr[gi]),
        .wr_bit  (seq_bit[gi]),
        .fire    (seq_fire[gi])
      );
    end
  endgenerate

  // ========================================================================
  // Register state
  cdr_regs_s q;
  cdr_regs_s d;

  always_comb begin
    d               = q;
    d.measure_start = 1'b0;

    // Register writes
    if (reg_wr_en) begin
      case (reg_wr_addr)
        `CDR_ADDR_CTL_A: begin
          d.ctrl_a = reg_wr_data;
          d.ctrl_a[`CDR_CA_DIV_HI:`CDR_CA_DIV_LO] =
            clamp_div(reg_wr_data[`CDR_CA_DIV_HI:`CDR_CA_DIV_LO]);
          if (reg_wr_data[`CDR_CA_MEASURE] && !q.ctrl_a[`CDR_CA_MEASURE]) begin
            d.measure_start = 1'b1;
          end
        end
        `CDR_ADDR_CTL_B: begin
          d.ctrl_b = reg_wr_data;
        end
        `CDR_ADDR_CTL_C: begin
          d.ctrl_c = reg_wr_data;
        end
        `CDR_ADDR_BER_CTL_A: begin
          d.ber_ctl = reg_wr_data;
        end
        `CDR_ADDR_UPPER: begin
          d.upper_hi = reg_wr_data;
        end
        `CDR_ADDR_LOWER: begin
          d.lower_hi = reg_wr_data;
        end
        `CDR_ADDR_RATE_LSB: begin
          d.code_lsb = reg_wr_data[`CDR_LSB_UPPER:`CDR_LSB_LOWER];
        end
        `CDR_ADDR_PHASE: begin
          d.phase = clamp_phase(reg_wr_data[5:0]);
        end
        default: begin
        end
      endcase
    end

    // Sticky lock loss: a set in the same cycle as a clear wins
    if (seq_fire[`CDR_SEQ_CLR_STICKY]) begin
      d.lock_sticky = 1'b0;
    end
    if (lock_s) begin
      d.lock_sticky = 1'b1;
    end

    // Rate measurement complete: cleared by sequence or a new start
    d.rate_prev = rate_s;
    if (seq_fire[`CDR_SEQ_CLR_RATE] || d.measure_start) begin
      d.rate_done = 1'b0;
    end
    if (rate_s && !q.rate_prev) begin
      d.rate_done = 1'b1;
    end

    // Error count captured once the core reports the end of a measurement
    d.ber_prev = ber_done_s;
    if (ber_done_s && !q.ber_prev) begin
      d.err_cnt = err_s;
    end

    // Converter word taken only when two synchronised samples agree
    d.dac_prev = dac_s;
    if (dac_s == q.dac_prev) begin
      d.dac_hold = dac_s;
    end

    // Pins
    if (d.ctrl_b[`CDR_CB_PIN_STICKY]) begin
      d.lock_pin = d.lock_sticky;
    end else begin
      d.lock_pin = lock_s;
    end
    d.loss_pin     = loss_s ^ d.ctrl_c[`CDR_CC_LOSS_POL];
    d.squelch_data = loss_s;
    d.squelch_clk  = loss_s && !d.ctrl_c[`CDR_CC_SQUELCH];

    // Register reads
    if (reg_rd_en) begin
      case (reg_rd_addr)
        `CDR_ADDR_STATUS: begin
          d.rd_data                 = `CDR_RST_BYTE;
          d.rd_data[`CDR_ST_LOSS]   = loss_s;
          d.rd_data[`CDR_ST_STICKY] = q.lock_sticky;
          d.rd_data[`CDR_ST_LOCK]   = lock_s;
          d.rd_data[`CDR_ST_RATE]   = q.rate_done;
          d.rd_data[`CDR_ST_COARSE] = coarse_s;
        end
        `CDR_ADDR_CTL_A_RD: begin
          d.rd_data = q.ctrl_a;
        end
        `CDR_ADDR_CTL_B_RD: begin
          d.rd_data = q.ctrl_b;
        end
        `CDR_ADDR_BER_STS: begin
          d.rd_data                = `CDR_RST_BYTE;
          d.rd_data[`CDR_BS_DONE]  = ber_done_s;
        end
        `CDR_ADDR_BER_RESULT: begin
          d.rd_data = pick_byte(q.err_cnt,
                                q.ber_ctl[`CDR_BA_SEL_HI:`CDR_BA_SEL_LO]);
        end
        `CDR_ADDR_BER_CONV: begin
          d.rd_data = {2'h0, q.dac_hold};
        end
        default: begin
          d.rd_data = `CDR_RST_BYTE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ========================================================================
  // Outputs, all taken from flip-flops
  assign reg_rd_data       = q.rd_data;
  assign lock_to_reference = q.ctrl_a[`CDR_CA_LOCK_REF];
  assign measure_start     = q.measure_start;
  assign ref_range         = q.ctrl_a[`CDR_CA_RANGE_HI:`CDR_CA_RANGE_LO];
  assign div_ratio_exp     = q.ctrl_a[`CDR_CA_DIV_HI:`CDR_CA_DIV_LO];
  assign start_acquisition = seq_fire[`CDR_SEQ_ACQUIRE];
  assign lock_loss_pin     = q.lock_pin;
  assign signal_loss_pin   = q.loss_pin;
  assign squelch_clk       = q.squelch_clk;
  assign squelch_data      = q.squelch_data;
  assign upper_rate_bound  = {q.upper_hi, q.code_lsb[`CDR_LSB_UPPER]};
  assign lower_rate_bound  = {q.lower_hi, q.code_lsb[`CDR_LSB_LOWER]};
  assign phase_code        = q.phase;
  assign bit_window_sel    = q.ber_ctl[`CDR_BA_TIMER_HI:`CDR_BA_TIMER_LO];
  assign ber_start         = seq_fire[`CDR_SEQ_BER_START];

endmodule : cdr_regs
`default_nettype wire

/* rtl/cdr_defs.svh */
// Register offsets, field positions, limits and reset values of the CDR register bank.
// Assumes inclusion by bare name from files under rtl/.
`ifndef CDR_DEFS_SVH
`define CDR_DEFS_SVH

// ==========================================================================
// Register offsets
`define CDR_ADDR_STATUS      8'h04
`define CDR_ADDR_CTL_A_RD    8'h05
`define CDR_ADDR_CTL_B_RD    8'h06
`define CDR_ADDR_CTL_A       8'h08
`define CDR_ADDR_CTL_B       8'h09
`define CDR_ADDR_CTL_C       8'h11
`define CDR_ADDR_BER_CTL_A   8'h1E
`define CDR_ADDR_BER_STS     8'h20
`define CDR_ADDR_BER_RESULT  8'h21
`define CDR_ADDR_BER_CONV    8'h24
`define CDR_ADDR_UPPER       8'h35
`define CDR_ADDR_LOWER       8'h36
`define CDR_ADDR_PHASE       8'h37
`define CDR_ADDR_RATE_LSB    8'h39

// ==========================================================================
// Field positions
`define CDR_ST_LOSS          5
`define CDR_ST_STICKY        4
`define CDR_ST_LOCK          3
`define CDR_ST_RATE          2
`define CDR_ST_COARSE        0
`define CDR_CA_LOCK_REF      0
`define CDR_CA_MEASURE       1
`define CDR_CA_DIV_LO        2
`define CDR_CA_DIV_HI        5
`define CDR_CA_RANGE_LO      6
`define CDR_CA_RANGE_HI      7
`define CDR_CB_PIN_STICKY    7
`define CDR_CB_CLR_STICKY    6
`define CDR_CB_ACQUIRE       5
`define CDR_CB_CLR_RATE      3
`define CDR_CC_LOSS_POL      2
`define CDR_CC_SQUELCH       1
`define CDR_BA_TIMER_LO      5
`define CDR_BA_TIMER_HI      7
`define CDR_BA_START         3
`define CDR_BA_SEL_LO        0
`define CDR_BA_SEL_HI        2
`define CDR_BS_DONE          0
`define CDR_LSB_UPPER        1
`define CDR_LSB_LOWER        0

// ==========================================================================
// Limits, sequence slots and reset values
`define CDR_PHASE_MAX        6'sh1E
`define CDR_PHASE_MIN        6'sh22
`define CDR_DIV_MAX          4'h8
`define CDR_ERR_BYTES        3'h5
`define CDR_NUM_SEQ          4
`define CDR_SEQ_CLR_STICKY   0
`define CDR_SEQ_CLR_RATE     1
`define CDR_SEQ_ACQUIRE      2
`define CDR_SEQ_BER_START    3
`define CDR_NUM_ASYNC        51
`define CDR_RST_BYTE         8'h00
`define CDR_RST_PHASE        6'h00

`endif

/* rtl/cdr_pkg.sv */
// State types of the CDR register bank.
// Assumes cdr_defs.svh is not needed here; widths are fixed.
package cdr_pkg;

  // ========================================================================
  // Synchroniser state
  typedef struct packed {
    logic meta;
    logic stable;
  } cdr_sync_s;

  // ========================================================================
  // Write-1-then-0 detector state
  typedef struct packed {
    logic armed;
    logic fire;
  } cdr_seq_s;

  // ========================================================================
  // Register bank state
  typedef struct packed {
    logic [7:0]  ctrl_a;
    logic [7:0]  ctrl_b;
    logic [7:0]  ctrl_c;
    logic [7:0]  ber_ctl;
    logic [7:0]  upper_hi;
    logic [7:0]  lower_hi;
    logic [1:0]  code_lsb;
    logic [5:0]  phase;
    logic        lock_sticky;
    logic        rate_done;
    logic        rate_prev;
    logic        ber_prev;
    logic [39:0] err_cnt;
    logic [5:0]  dac_prev;
    logic [5:0]  dac_hold;
    logic        measure_start;
    logic        lock_pin;
    logic        loss_pin;
    logic        squelch_clk;
    logic        squelch_data;
    logic [7:0]  rd_data;
  } cdr_regs_s;

endpackage : cdr_pkg

/* rtl/cdr_sync.sv */
// Two-flop synchroniser for one asynchronous level.
// Assumes the input is a level that stays put for several ref_clk periods.
`timescale 1ns/1ps
`default_nettype none

module cdr_sync
  import cdr_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  input  wire logic async_in,
  output logic      sync_out
);

  cdr_sync_s q;
  cdr_sync_s d;

  always_comb begin
    d        = q;
    d.meta   = async_in;
    d.stable = q.meta;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign sync_out = q.stable;

endmodule : cdr_sync
`default_nettype wire

/* rtl/cdr_seq.sv */
// Detects a write of 1 followed by a write of 0 to one control bit.
// Assumes wr_en is a one-cycle strobe of a write to the register holding the bit.
`timescale 1ns/1ps
`default_nettype none

module cdr_seq
  import cdr_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  input  wire logic wr_en,
  input  wire logic wr_bit,
  output logic      fire
);

  cdr_seq_s q;
  cdr_seq_s d;

  always_comb begin
    d       = q;
    d.fire  = 1'b0;
    if (wr_en) begin
      if (wr_bit) begin
        d.armed = 1'b1;
      end else if (q.armed) begin
        d.armed = 1'b0;
        d.fire  = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign fire = q.fire;

endmodule : cdr_seq
`default_nettype wire

/* verif/cdr_regs_assertions.sv */
// Concurrent checks of the register bank ports.
// Assumes a bind to cdr_regs, one ref_clk domain, synchronous sys_rst.
`timescale 1ns/1ps
`default_nettype none

module cdr_regs_assertions (
  input wire logic       ref_clk,
  input wire logic       sys_rst,
  input wire logic       reg_wr_en,
  input wire logic [7:0] reg_wr_addr,
  input wire logic [7:0] reg_wr_data,
  input wire logic       reg_rd_en,
  input wire logic [7:0] reg_rd_addr,
  input wire logic [7:0] reg_rd_data,
  input wire logic       core_signal_loss,
  input wire logic       core_lock_loss,
  input wire logic       lock_to_reference,
  input wire logic       measure_start,
  input wire logic       start_acquisition,
  input wire logic       lock_loss_pin,
  input wire logic       signal_loss_pin,
  input wire logic       squelch_clk,
  input wire logic       squelch_data,
  input wire logic [5:0] phase_code
);
  // ====================
  // Shadow of control bits
  logic cfg_q;
  logic pol_q;
  logic sqm_q;
  logic arm_q;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cfg_q <= 1'b0;
      arm_q <= 1'b0;
      pol_q <= 1'b0;
      sqm_q <= 1'b0;
    end else if (reg_wr_en && reg_wr_addr == 8'h09) begin
      cfg_q <= reg_wr_data[7];
      arm_q <= reg_wr_data[5];
    end else if (reg_wr_en && reg_wr_addr == 8'h11) begin
      pol_q <= reg_wr_data[2];
      sqm_q <= reg_wr_data[1];
    end
  end

  // ====================
  // Properties
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  sequence s_ctla_wr;
    reg_wr_en && reg_wr_addr == 8'h08;
  endsequence
  sequence s_acq_fire;
    reg_wr_en && reg_wr_addr == 8'h09 && !reg_wr_data[5] && arm_q;
  endsequence
  sequence s_loss_hold;
    ($stable(core_signal_loss) && $stable(pol_q) && $stable(sqm_q))[*4];
  endsequence

  AST_LOCK_SRC: assert property (s_ctla_wr |=> lock_to_reference == $past(reg_wr_data[0]))
    else $error("lock source differs from written bit");
  AST_MEASURE: assert property (measure_start |-> $past(reg_wr_en && reg_wr_addr == 8'h08
    && reg_wr_data[1])) else $error("measure strobe without a write");
  AST_ACQ: assert property (s_acq_fire |=> ##[0:1] start_acquisition)
    else $error("no acquisition strobe after one then zero");
  AST_ACQ_ONE: assert property (start_acquisition |=> !start_acquisition)
    else $error("acquisition strobe longer than one cycle");
  AST_LOCK_PIN: assert property ((!cfg_q && !core_lock_loss)[*4] |-> !lock_loss_pin)
    else $error("lock loss pin high while locked in normal mode");
  AST_STICKY: assert property (core_lock_loss[*5] |-> lock_loss_pin)
    else $error("lock loss pin low during lock loss");
  AST_SIG_PIN: assert property (s_loss_hold |->
    signal_loss_pin == (core_signal_loss ^ pol_q))
    else $error("signal loss pin polarity wrong");
  AST_SQUELCH: assert property (s_loss_hold ##0 core_signal_loss |-> squelch_data
    && squelch_clk == !sqm_q) else $error("squelch outputs wrong");
  AST_PHASE: assert property ($signed(phase_code) <= 30 && $signed(phase_code) >= -30)
    else $error("phase code out of range");
  AST_DAC: assert property (reg_rd_en && reg_rd_addr == 8'h24 |=>
    reg_rd_data[7:6] == 2'b00) else $error("converter readback upper bits set");
  AST_RD_HOLD: assert property (!$past(reg_rd_en) |-> $stable(reg_rd_data))
    else $error("read data changed without a read");
endmodule : cdr_regs_assertions

bind cdr_regs cdr_regs_assertions u_chk (.ref_clk(ref_clk), .sys_rst(sys_rst),
  .reg_wr_en(reg_wr_en), .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data),
  .reg_rd_en(reg_rd_en), .reg_rd_addr(reg_rd_addr), .reg_rd_data(reg_rd_data),
  .core_signal_loss(core_signal_loss), .core_lock_loss(core_lock_loss),
  .lock_to_reference(lock_to_reference), .measure_start(measure_start),
  .start_acquisition(start_acquisition), .lock_loss_pin(lock_loss_pin),
  .signal_loss_pin(signal_loss_pin), .squelch_clk(squelch_clk),
  .squelch_data(squelch_data), .phase_code(phase_code));
`default_nettype wire

/* verif/cdr_host_model.sv */
// Host side of the register port: single-cycle writes and reads.
// Assumes the bank samples strobes at rising ref_clk; drives at falling edges.
`timescale 1ns/1ps
`default_nettype none

module cdr_host_model (
  input  wire logic       ref_clk,
  output logic            reg_wr_en,
  output logic      [7:0] reg_wr_addr,
  output logic      [7:0] reg_wr_data,
  output logic            reg_rd_en,
  output logic      [7:0] reg_rd_addr,
  input  wire logic [7:0] reg_rd_data
);
  initial begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_wr_addr = 8'h00;
    reg_wr_data = 8'h00;
    reg_rd_addr = 8'h00;
  end
  // Released lines show the inverse so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_wr_en = 1'b1;
    reg_wr_addr = a;
    reg_wr_data = d;
    @(posedge ref_clk);
    @(negedge ref_clk);
    reg_wr_en = 1'b0;
    reg_wr_addr = ~a;
    reg_wr_data = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    reg_rd_en = 1'b1;
    reg_rd_addr = a;
    @(posedge ref_clk);
    @(negedge ref_clk);
    d = reg_rd_data;
    reg_rd_en = 1'b0;
    reg_rd_addr = ~a;
  endtask : rd
  // Write the bit as one then zero
  task automatic one_zero(input logic [7:0] a, input logic [7:0] d);
    wr(a, d);
    wr(a, 8'h00);
  endtask : one_zero
endmodule : cdr_host_model
`default_nettype wire

/* verif/cdr_control_status_registers_tb.sv */
// Self-checking bench of the register bank with random and corner stimulus.
// Assumes cdr_host_model drives the register port; core inputs at falling edges.
`timescale 1ns/1ps
`default_nettype none

module cdr_control_status_registers_tb;
  logic        ref_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        reg_wr_en, reg_rd_en;
  logic [7:0]  reg_wr_addr, reg_wr_data, reg_rd_addr, reg_rd_data;
  logic        core_signal_loss = 1'b0, core_lock_loss = 1'b0, core_rate_done = 1'b0;
  logic        core_coarse_lsb = 1'b0, core_ber_done = 1'b0;
  logic [39:0] core_error_count = 40'h0, cnt;
  logic [5:0]  core_ber_converter_input = 6'h00, phase_code;
  logic        lock_to_reference, measure_start, start_acquisition, lock_loss_pin;
  logic        signal_loss_pin, squelch_clk, squelch_data, ber_start;
  logic [1:0]  ref_range;
  logic [3:0]  div_ratio_exp;
  logic [8:0]  upper_rate_bound, lower_rate_bound;
  logic [2:0]  bit_window_sel;
  logic [7:0]  rd, d, h, l, c;
  int          errors = 0, n_checks = 0, cyc = 0, v, i;
  int          ph[8] = '{0, 30, 31, -30, -31, -32, -6, 15};

  initial forever #50 ref_clk = ~ref_clk;

  cdr_host_model u_host (.ref_clk(ref_clk), .reg_wr_en(reg_wr_en), .reg_wr_addr(reg_wr_addr),
    .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .reg_rd_addr(reg_rd_addr),
    .reg_rd_data(reg_rd_data));
  cdr_regs u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_wr_en(reg_wr_en),
    .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en),
    .reg_rd_addr(reg_rd_addr), .reg_rd_data(reg_rd_data), .core_signal_loss(core_signal_loss),
    .core_lock_loss(core_lock_loss), .core_rate_done(core_rate_done),
    .core_coarse_lsb(core_coarse_lsb), .core_ber_done(core_ber_done),
    .core_error_count(core_error_count), .core_ber_converter_input(core_ber_converter_input),
    .lock_to_reference(lock_to_reference), .measure_start(measure_start),
    .ref_range(ref_range), .div_ratio_exp(div_ratio_exp), .start_acquisition(start_acquisition),
    .lock_loss_pin(lock_loss_pin), .signal_loss_pin(signal_loss_pin), .squelch_clk(squelch_clk),
    .squelch_data(squelch_data), .upper_rate_bound(upper_rate_bound),
    .lower_rate_bound(lower_rate_bound), .phase_code(phase_code),
    .bit_window_sel(bit_window_sel), .ber_start(ber_start));

  // ====================
  // Checking helpers
  task chk(input string nm, input logic [39:0] seen, input logic [39:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk
  task rdc(input string nm, input logic [7:0] a, input logic [7:0] e);
    u_host.rd(a, rd);
    chk(nm, rd, e);
  endtask : rdc
  task end_of_test();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_of_test
  function logic [5:0] sat(input int x);
    return x > 30 ? 6'h1E : (x < -30 ? 6'h22 : x[5:0]);
  endfunction : sat

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      end_of_test();
    end
  end

  // ====================
  // Main sequence
  initial begin
    v = $urandom(10);
    repeat (12) @(negedge ref_clk);
    sys_rst = 1'b0;
    rdc("misc", 8'h04, 8'h00);
    rdc("ctla_rd", 8'h05, 8'h00);
    rdc("unmapped", 8'h50, 8'h00);
    rdc("write_only", 8'h08, 8'h00);
    for (i = 0; i < 8; i++) begin
      d = (i == 0) ? 8'hFF : 8'($urandom);
      u_host.wr(8'h08, d);
      chk("lock_ref", lock_to_reference, d[0]);
      chk("range", ref_range, d[7:6]);
      chk("div", div_ratio_exp, (d[5:2] > 4'h8) ? 4'h8 : d[5:2]);
    end
    rdc("ctla_rd", 8'h05, {d[7:6], ((d[5:2] > 4'h8) ? 4'h8 : d[5:2]), d[1:0]});
    u_host.wr(8'h08, 8'h00);
    u_host.wr(8'h08, 8'h02);
    chk("measure", measure_start, 1'b1);
    for (i = 0; i < 8; i++) begin
      v = (i == 7) ? int'($urandom % 61) - 30 : ph[i];
      u_host.wr(8'h37, {2'b00, v[5:0]});
      chk("phase", phase_code, sat(v));
    end
    for (i = 0; i < 4; i++) begin
      h = $urandom;
      l = $urandom;
      c = $urandom;
      u_host.wr(8'h35, h);
      u_host.wr(8'h36, l);
      u_host.wr(8'h39, {6'h00, c[1:0]});
      chk("upper", upper_rate_bound, {h, c[1]});
      chk("lower", lower_rate_bound, {l, c[0]});
    end
    cnt = {8'($urandom), 32'($urandom)};
    core_error_count = cnt;
    repeat (2) @(negedge ref_clk);
    core_ber_done = 1'b1;
    repeat (6) @(negedge ref_clk);
    rdc("done_flag", 8'h20, 8'h01);
    for (i = 0; i < 8; i++) begin
      d = {3'($urandom), 2'b00, 3'(i)};
      u_host.wr(8'h1E, d);
      chk("window", bit_window_sel, d[7:5]);
      rdc("result", 8'h21, (i < 5) ? cnt[8*i +: 8] : 8'h00);
    end
    u_host.one_zero(8'h1E, 8'h08);
    for (i = 0; i < 4 && ber_start !== 1'b1; i++) @(negedge ref_clk);
    chk("ber_start", ber_start, 1'b1);
    core_ber_done = 1'b0;
    core_ber_converter_input = 6'($urandom);
    repeat (4) @(negedge ref_clk);
    rdc("converter", 8'h24, {2'b00, core_ber_converter_input});
    core_signal_loss = 1'b1;
    core_lock_loss = 1'b1;
    core_rate_done = 1'b1;
    core_coarse_lsb = 1'b1;
    repeat (6) @(negedge ref_clk);
    rdc("misc", 8'h04, 8'h3D);
    chk("los_pin", signal_loss_pin, 1'b1);
    chk("sq_clk", squelch_clk, 1'b1);
    chk("sq_data", squelch_data, 1'b1);
    core_lock_loss = 1'b0;
    repeat (6) @(negedge ref_clk);
    rdc("misc", 8'h04, 8'h35);
    chk("lol_pin", lock_loss_pin, 1'b0);
    u_host.wr(8'h09, 8'h80);
    rdc("ctlb_rd", 8'h06, 8'h80);
    repeat (3) @(negedge ref_clk);
    chk("lol_pin", lock_loss_pin, 1'b1);
    u_host.one_zero(8'h09, 8'h40);
    repeat (3) @(negedge ref_clk);
    rdc("misc", 8'h04, 8'h25);
    u_host.one_zero(8'h09, 8'h08);
    repeat (3) @(negedge ref_clk);
    rdc("misc", 8'h04, 8'h21);
    u_host.wr(8'h11, 8'h06);
    repeat (3) @(negedge ref_clk);
    chk("los_pin", signal_loss_pin, 1'b0);
    chk("sq_clk", squelch_clk, 1'b0);
    chk("sq_data", squelch_data, 1'b1);
    u_host.one_zero(8'h09, 8'h20);
    for (i = 0; i < 4 && start_acquisition !== 1'b1; i++) @(negedge ref_clk);
    chk("acquire", start_acquisition, 1'b1);
    core_signal_loss = 1'b0;
    sys_rst = 1'b1;
    repeat (3) @(negedge ref_clk);
    sys_rst = 1'b0;
    rdc("ctla_rd", 8'h05, 8'h00);
    rdc("ctlb_rd", 8'h06, 8'h00);
    end_of_test();
  end
endmodule : cdr_control_status_registers_tb
`default_nettype wire
